/* rtl/alarm_channel.sv */
// One alarm channel: detection, delay and silence timing
`timescale 1ns/10ps
`default_nettype none
module alarm_channel (
  input  wire logic                             clk_in,
  input  wire logic                             resetn_in,
  input  wire logic                             ce_in,
  input  wire logic                             tick_in,
  input  wire logic                             blink_in,
  input  wire logic                             enable_in,
  input  wire logic                             high_low_selection_in,
  input  wire logic                             is_rate_in,
  input  wire logic signed [alarm_pkg::VAL_W-1:0] value_in,
  input  wire logic signed [alarm_pkg::VAL_W-1:0] setpoint_in,
  input  wire logic signed [alarm_pkg::VAL_W-1:0] rate_hysteresis_value_in,
  input  wire logic [11:0]                      delay_in,
  input  wire logic [11:0]                      silence_in,
  input  wire logic                             accept_in,
  output logic                                  active_out,
  output logic                                  annunciator_out
);
  typedef struct packed {
    logic        cond;
    logic        active;
    logic        silenced;
    logic [11:0] delay_cnt;
    logic [11:0] sil_cnt;
  } ch_s;

  ch_s st_reg;
  ch_s st_next;
  logic signed [alarm_pkg::VAL_W-1:0] hyst;
  logic [11:0] delay_lim;

  // Condition with hysteresis, timers and silence
  always_comb begin
    st_next   = st_reg;
    hyst      = is_rate_in ? rate_hysteresis_value_in : '0;
    delay_lim = (delay_in > alarm_pkg::DELAY_MAX_S) ?
                alarm_pkg::DELAY_MAX_S : delay_in;
    if (!enable_in) begin
      st_next = '0;
    end else begin
      if (high_low_selection_in) begin
        if (value_in >= setpoint_in) st_next.cond = 1'b1;
        else if (value_in < setpoint_in - hyst) st_next.cond = 1'b0;
      end else begin
        if (value_in <= setpoint_in) st_next.cond = 1'b1;
        else if (value_in > setpoint_in + hyst) st_next.cond = 1'b0;
      end
      if (!st_reg.cond) begin
        st_next.delay_cnt = '0;
        st_next.active    = 1'b0;
        st_next.silenced  = 1'b0;
      end else if (!st_reg.active) begin
        if (st_reg.delay_cnt >= delay_lim) begin
          st_next.active = 1'b1;
        end else if (tick_in) begin
          st_next.delay_cnt = st_reg.delay_cnt + 12'h001;
        end
      end else if (st_reg.silenced) begin
        if (tick_in) begin
          if (st_reg.sil_cnt <= 12'h001) st_next.silenced = 1'b0;
          st_next.sil_cnt = st_reg.sil_cnt - 12'h001;
        end
      end else if (accept_in && silence_in != 12'h000) begin
        st_next.silenced = 1'b1;
        st_next.sil_cnt  = silence_in;
      end
    end
  end

  // State register, frozen when clock enable is low
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg <= '0;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  assign active_out = st_reg.active && !st_reg.silenced;
  // Flash during delay or silence, steady once active
  assign annunciator_out = st_reg.cond &&
    ((st_reg.active && !st_reg.silenced) || blink_in);

  // Zero delay acts at once; an accept must drop the output
  a_zero_delay: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && enable_in && st_reg.cond && !st_reg.active &&
    delay_in == 12'h000 |=> st_reg.active)
    else $error("zero delay not immediate");
  a_silence_release: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && st_reg.active && !st_reg.silenced && accept_in &&
    silence_in != 12'h000 |=> !active_out)
    else $error("accepted alarm still active");
endmodule
`default_nettype wire

/* rtl/alarm_timing_annunciator.sv */
// Two-alarm timing, annunciator, display alternation and setpoint menu
`timescale 1ns/10ps
`default_nettype none
module alarm_timing_annunciator #(
  // Clocks per one-second tick; a bench may shorten it
  parameter int unsigned TICK_CYCLES = alarm_pkg::TICK_CYCLES
) (
  input  wire logic                               clk_in,
  input  wire logic                               resetn_in,
  input  wire logic                               ce_in,
  // Raw front panel buttons, asynchronous
  input  wire logic                               btn_p_in,
  input  wire logic                               btn_up_in,
  input  wire logic                               btn_down_in,
  input  wire logic                               btn_enter_in,
  // Process values and view
  input  wire logic signed [alarm_pkg::VAL_W-1:0] value1_in,
  input  wire logic signed [alarm_pkg::VAL_W-1:0] value2_in,
  input  wire logic [1:0]                         view_sel_in,
  input  wire logic [1:0]                         alarm1_input_in,
  input  wire logic [1:0]                         alarm2_input_in,
  // Configuration
  input  wire logic [1:0]                         enable_in,
  input  wire logic [1:0]                         high_low_selection_in,
  input  wire logic [1:0]                         is_rate_in,
  input  wire logic [1:0]                         output_polarity_option_in,
  input  wire logic signed [alarm_pkg::VAL_W-1:0] setpoint1_in,
  input  wire logic signed [alarm_pkg::VAL_W-1:0] setpoint2_in,
  input  wire logic signed [alarm_pkg::VAL_W-1:0] rate_hysteresis_value1_in,
  input  wire logic signed [alarm_pkg::VAL_W-1:0] rate_hysteresis_value2_in,
  input  wire logic [11:0]                        activation_delay_time1_in,
  input  wire logic [11:0]                        activation_delay_time2_in,
  input  wire logic [11:0]                        silence_time1_in,
  input  wire logic [11:0]                        silence_time2_in,
  input  wire logic                               flash_on_alarm_enable_in,
  input  wire logic                               direct_setpoint_menu_enable_in,
  input  wire logic [15:0]                        security_code_entry_in,
  input  wire logic [15:0]                        code_digits_in,
  // Outputs
  output logic [1:0]                              alarm_switch_out,
  output logic [1:0]                              annunciator_out,
  output logic                                    show_identifier_out,
  output logic                                    security_code_prompt_out,
  output logic                                    code_entry_out,
  output logic                                    rate_setpoint_prompt_out,
  output logic                                    total_setpoint_prompt_out,
  output logic                                    setpoint_edit_out,
  output logic                                    selected_alarm_out,
  output logic                                    digit_flash_out,
  output logic                                    accept_mode_out
);
  typedef struct packed {
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [3:0]  prev;
    logic [24:0] div;
    logic        tick;
    logic        blink;
    alarm_pkg::menu_e menu;
    logic [3:0]  idle;
    logic        sel;
    logic [15:0] code_active;
    logic [1:0]  sw;
    logic [1:0]  ann;
    logic        ident;
    logic [7:0]  pr;
  } top_s;

  top_s st_reg;
  top_s st_next;
  logic [1:0] ch_active;
  logic [1:0] ch_ann;
  logic [3:0] btn;
  logic [3:0] press;
  logic       accept_mode;
  logic       any_press;
  logic       alt1;
  logic       alt2;

  assign btn = {btn_enter_in, btn_down_in, btn_up_in, btn_p_in};
  assign press = st_reg.sync2 & ~st_reg.prev;
  assign any_press = |press;
  // Accept role only with nonzero silence and outside menus
  assign accept_mode = ((silence_time1_in != 12'h000) ||
                        (silence_time2_in != 12'h000)) &&
                       st_reg.menu == alarm_pkg::MENU_TOTALISING;

  alarm_channel u_alarm1 (
    .clk_in                   (clk_in),
    .resetn_in                (resetn_in),
    .ce_in                    (ce_in),
    .tick_in                  (st_reg.tick),
    .blink_in                 (st_reg.blink),
    .enable_in                (enable_in[0]),
    .high_low_selection_in    (high_low_selection_in[0]),
    .is_rate_in               (is_rate_in[0]),
    .value_in                 (value1_in),
    .setpoint_in              (setpoint1_in),
    .rate_hysteresis_value_in (rate_hysteresis_value1_in),
    .delay_in                 (activation_delay_time1_in),
    .silence_in               (silence_time1_in),
    .accept_in                (accept_mode && press[0]),
    .active_out               (ch_active[0]),
    .annunciator_out          (ch_ann[0])
  );

  alarm_channel u_alarm2 (
    .clk_in                   (clk_in),
    .resetn_in                (resetn_in),
    .ce_in                    (ce_in),
    .tick_in                  (st_reg.tick),
    .blink_in                 (st_reg.blink),
    .enable_in                (enable_in[1]),
    .high_low_selection_in    (high_low_selection_in[1]),
    .is_rate_in               (is_rate_in[1]),
    .value_in                 (value2_in),
    .setpoint_in              (setpoint2_in),
    .rate_hysteresis_value_in (rate_hysteresis_value2_in),
    .delay_in                 (activation_delay_time2_in),
    .silence_in               (silence_time2_in),
    .accept_in                (accept_mode && press[0]),
    .active_out               (ch_active[1]),
    .annunciator_out          (ch_ann[1])
  );

  // Alternate only when viewing the alarm's own input
  assign alt1 = ch_active[0] && view_sel_in == alarm1_input_in;
  assign alt2 = ch_active[1] && view_sel_in == alarm2_input_in;

  // Tick divider, synchronisers, outputs and menu
  always_comb begin
    st_next       = st_reg;
    st_next.sync1 = btn;
    st_next.sync2 = st_reg.sync1;
    st_next.prev  = st_reg.sync2;
    st_next.tick  = 1'b0;
    if (st_reg.div == 25'(TICK_CYCLES - 1)) begin
      st_next.div   = '0;
      st_next.tick  = 1'b1;
      st_next.blink = ~st_reg.blink;
    end else begin
      st_next.div = st_reg.div + 25'h0000001;
    end
    // Output switch follows polarity when idle
    st_next.sw  = ch_active ^ output_polarity_option_in;
    st_next.ann = ch_ann;
    st_next.ident = flash_on_alarm_enable_in && (alt1 || alt2) &&
                    st_reg.blink;
    if (any_press) st_next.idle = '0;
    else if (st_reg.tick && st_reg.menu != alarm_pkg::MENU_TOTALISING)
      st_next.idle = st_reg.idle + 4'h1;
    case (st_reg.menu)
      alarm_pkg::MENU_TOTALISING: begin
        st_next.code_active = security_code_entry_in;
        st_next.idle = '0;
        if (st_reg.sync2[0] && st_reg.sync2[3] &&
            (press[0] || press[3]) && direct_setpoint_menu_enable_in) begin
          if (security_code_entry_in == alarm_pkg::CODE_OFF)
            st_next.menu = alarm_pkg::MENU_SP_PROMPT;
          else
            st_next.menu = alarm_pkg::MENU_CODE_PROMPT;
        end
      end
      alarm_pkg::MENU_CODE_PROMPT: begin
        if (press[0]) st_next.menu = alarm_pkg::MENU_CODE_ENTRY;
      end
      alarm_pkg::MENU_CODE_ENTRY: begin
        if (press[3]) begin
          if (code_digits_in == st_reg.code_active)
            st_next.menu = alarm_pkg::MENU_SP_PROMPT;
          else
            st_next.menu = alarm_pkg::MENU_TOTALISING;
        end
      end
      alarm_pkg::MENU_SP_PROMPT: begin
        if (press[1] || press[2]) st_next.sel = ~st_reg.sel;
        else if (press[0]) st_next.menu = alarm_pkg::MENU_SP_EDIT;
        else if (press[3]) st_next.menu = alarm_pkg::MENU_TOTALISING;
      end
      alarm_pkg::MENU_SP_EDIT: begin
        if (press[3]) st_next.menu = alarm_pkg::MENU_SP_PROMPT;
      end
      default: st_next.menu = alarm_pkg::MENU_TOTALISING;
    endcase
    if (st_reg.menu != alarm_pkg::MENU_TOTALISING &&
        st_reg.idle >= alarm_pkg::IDLE_TIMEOUT_S && !any_press) begin
      st_next.menu = alarm_pkg::MENU_TOTALISING;
      st_next.idle = '0;
    end
    if (st_next.menu == alarm_pkg::MENU_TOTALISING) st_next.sel = 1'b0;
    // Prompt flags registered from next menu state
    st_next.pr[0] = st_next.menu == alarm_pkg::MENU_CODE_PROMPT;
    st_next.pr[1] = st_next.menu == alarm_pkg::MENU_CODE_ENTRY;
    st_next.pr[2] = st_next.menu == alarm_pkg::MENU_SP_PROMPT &&
                    is_rate_in[st_next.sel];
    st_next.pr[3] = st_next.menu == alarm_pkg::MENU_SP_PROMPT &&
                    !is_rate_in[st_next.sel];
    st_next.pr[4] = st_next.menu == alarm_pkg::MENU_SP_EDIT;
    st_next.pr[5] = st_next.sel;
    st_next.pr[6] = st_next.blink &&
                    (st_next.pr[1] || st_next.pr[4]);
    st_next.pr[7] = accept_mode;
  end

  // Single state register, frozen by clock enable
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg      <= '0;
      st_reg.menu <= alarm_pkg::MENU_TOTALISING;
      st_reg.sw   <= 2'h0;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  assign alarm_switch_out          = st_reg.sw;
  assign annunciator_out           = st_reg.ann;
  assign show_identifier_out       = st_reg.ident;
  assign security_code_prompt_out  = st_reg.pr[0];
  assign code_entry_out            = st_reg.pr[1];
  assign rate_setpoint_prompt_out  = st_reg.pr[2];
  assign total_setpoint_prompt_out = st_reg.pr[3];
  assign setpoint_edit_out         = st_reg.pr[4];
  assign selected_alarm_out        = st_reg.pr[5];
  assign digit_flash_out           = st_reg.pr[6];
  assign accept_mode_out           = st_reg.pr[7];

  // Menu entry and code guards
  a_menu_gated: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    st_reg.menu == alarm_pkg::MENU_TOTALISING &&
    !direct_setpoint_menu_enable_in
    |=> st_reg.menu == alarm_pkg::MENU_TOTALISING)
    else $error("menu opened while disabled");
  a_wrong_code: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && st_reg.menu == alarm_pkg::MENU_CODE_ENTRY && press[3] &&
    code_digits_in != st_reg.code_active
    |=> st_reg.menu == alarm_pkg::MENU_TOTALISING)
    else $error("wrong code accepted");
  // Stored code may only follow the setting in totalising mode
  a_code_latch: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    st_reg.menu != alarm_pkg::MENU_TOTALISING |=> $stable(st_reg.code_active))
    else $error("code changed inside menu");
  // Display side guards
  a_ident_view: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && !flash_on_alarm_enable_in |=> !show_identifier_out)
    else $error("identifier shown while disabled");
  a_ann_follow: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in |=> annunciator_out == $past(ch_ann))
    else $error("annunciator lag wrong");
  a_switch_pol: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in |=> alarm_switch_out ==
    ($past(ch_active) ^ $past(output_polarity_option_in)))
    else $error("switch polarity wrong");
  c_menu_open: cover property (@(posedge clk_in)
    st_reg.menu == alarm_pkg::MENU_SP_PROMPT);
  c_code_entry: cover property (@(posedge clk_in)
    st_reg.menu == alarm_pkg::MENU_CODE_ENTRY);
  c_alarm_on: cover property (@(posedge clk_in) ch_active[0]);
endmodule
`default_nettype wire

/* shared/alarm_pkg.sv */
// Constants and types shared by the alarm timing annunciator
package alarm_pkg;
  localparam int unsigned CLK_HZ         = 20000000;
  localparam int unsigned TICK_CYCLES    = CLK_HZ;       // One second
  localparam logic [11:0] DELAY_MAX_S    = 12'he10;      // 3600 seconds
  localparam logic [3:0]  IDLE_TIMEOUT_S = 4'ha;         // Ten seconds
  localparam logic [15:0] CODE_OFF       = 16'h0000;
  localparam logic [1:0]  FLASH_BIT      = 2'h0;         // Blink bit index
  localparam int unsigned VAL_W          = 32;

  // Front panel menu states
  typedef enum logic [2:0] {
    MENU_TOTALISING,
    MENU_CODE_PROMPT,
    MENU_CODE_ENTRY,
    MENU_SP_PROMPT,
    MENU_SP_EDIT
  } menu_e;

  // Display selector codes for the viewed or monitored input
  localparam logic [1:0] VIEW_A   = 2'h0;
  localparam logic [1:0] VIEW_B   = 2'h1;
  localparam logic [1:0] VIEW_SUM = 2'h2;
endpackage

/* verification/operator_panel.sv */
// Operator push-button model standing in front of the panel
`timescale 1ns/10ps
`default_nettype none
module operator_panel (
  input  wire logic clk_in,
  output logic      btn_p_out,
  output logic      btn_up_out,
  output logic      btn_down_out,
  output logic      btn_enter_out
);
  // Buttons rest released; the panel lines are pulled low
  initial begin
    btn_p_out     = 1'b0;
    btn_up_out    = 1'b0;
    btn_down_out  = 1'b0;
    btn_enter_out = 1'b0;
  end

  // Held four cycles so the two-stage synchroniser sees it
  task automatic press(input logic [3:0] mask);
    @(posedge clk_in);
    {btn_p_out, btn_up_out, btn_down_out, btn_enter_out} <= mask;
    repeat (4) @(posedge clk_in);
    {btn_p_out, btn_up_out, btn_down_out, btn_enter_out} <= 4'h0;
    repeat (8) @(posedge clk_in);
  endtask

  // Enter goes down while P is still held: the two-button chord
  task automatic chord();
    @(posedge clk_in);
    btn_p_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    btn_enter_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    btn_p_out     <= 1'b0;
    btn_enter_out <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

/* verification/tb_alarm_timing_annunciator.sv */
// Self-checking bench for the alarm timing annunciator
`timescale 1ns/10ps
`default_nettype none
module tb_alarm_timing_annunciator;
  localparam logic [3:0] BP = 4'h8;
  localparam logic [3:0] BU = 4'h4;
  localparam logic [3:0] BD = 4'h2;
  localparam logic [3:0] BE = 4'h1;
  localparam int unsigned TICK = 20;  // Shortened second, in clocks
  logic clk_in, resetn_in, ce_in, flash_en, menu_en;
  logic btn_p, btn_up, btn_down, btn_enter;
  logic signed [alarm_pkg::VAL_W-1:0] value1, value2, sp1, sp2, hy1, hy2;
  logic [1:0]  view_sel, in1_sel, in2_sel, enable, high_low, is_rate, pol;
  logic [11:0] delay1, delay2, silence1, silence2;
  logic [15:0] code_cfg, code_digits;
  logic [1:0]  alarm_switch, annunciator;
  logic        show_id, code_prompt, code_entry, rate_prompt, total_prompt;
  logic        sp_edit, sel_alarm, digit_flash, accept_mode;
  wire  logic [4:0] flags;
  int          err_total, samples_checked, cycles;

  // Menu outputs gathered: code prompt, entry, rate, total, edit
  assign flags = {code_prompt, code_entry, rate_prompt, total_prompt, sp_edit};

  alarm_timing_annunciator #(.TICK_CYCLES(TICK)) dut_u (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .btn_p_in(btn_p), .btn_up_in(btn_up), .btn_down_in(btn_down),
    .btn_enter_in(btn_enter), .value1_in(value1), .value2_in(value2),
    .view_sel_in(view_sel), .alarm1_input_in(in1_sel),
    .alarm2_input_in(in2_sel), .enable_in(enable),
    .high_low_selection_in(high_low), .is_rate_in(is_rate),
    .output_polarity_option_in(pol), .setpoint1_in(sp1),
    .setpoint2_in(sp2), .rate_hysteresis_value1_in(hy1),
    .rate_hysteresis_value2_in(hy2), .activation_delay_time1_in(delay1),
    .activation_delay_time2_in(delay2), .silence_time1_in(silence1),
    .silence_time2_in(silence2), .flash_on_alarm_enable_in(flash_en),
    .direct_setpoint_menu_enable_in(menu_en),
    .security_code_entry_in(code_cfg), .code_digits_in(code_digits),
    .alarm_switch_out(alarm_switch), .annunciator_out(annunciator),
    .show_identifier_out(show_id), .security_code_prompt_out(code_prompt),
    .code_entry_out(code_entry), .rate_setpoint_prompt_out(rate_prompt),
    .total_setpoint_prompt_out(total_prompt), .setpoint_edit_out(sp_edit),
    .selected_alarm_out(sel_alarm), .digit_flash_out(digit_flash),
    .accept_mode_out(accept_mode)
  );

  operator_panel panel_u (
    .clk_in(clk_in), .btn_p_out(btn_p), .btn_up_out(btn_up),
    .btn_down_out(btn_down), .btn_enter_out(btn_enter)
  );

  // 50 ns clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Alarm path needs condition, active and output register stages; six is ample
  task automatic settle();
    repeat (6) @(posedge clk_in);
  endtask

  task automatic test_reset();
    check(32'(alarm_switch), 32'h2);
    check(32'(annunciator), 32'h0);
    check(32'(flags), 32'h0);
    $display("test_reset done");
  endtask

  // Rate high alarm, zero delay, hysteresis band and enable gating
  task automatic test_rate_high();
    logic s0;
    value1 <= 32'sh0fa0;
    settle();
    check(32'(annunciator[0]), 32'h1);
    check(32'(alarm_switch[0]), 32'h1);
    // Blink toggles each tick, so samples a tick apart differ
    s0 = show_id;
    repeat (TICK) @(posedge clk_in);
    check(32'(show_id ^ s0), 32'h1);
    flash_en <= 1'b0;
    settle();
    check(32'(show_id), 32'h0);
    repeat (TICK) @(posedge clk_in);
    check(32'(show_id), 32'h0);
    flash_en <= 1'b1;
    view_sel <= alarm_pkg::VIEW_B;
    settle();
    check(32'(show_id), 32'h0);
    repeat (TICK) @(posedge clk_in);
    check(32'(show_id), 32'h0);
    check(32'(annunciator[0]), 32'h1);
    value1 <= 32'sh0f6e;
    settle();
    check(32'(annunciator[0]), 32'h1);
    value1 <= 32'sh0f3b;
    settle();
    check(32'(alarm_switch[0]), 32'h0);
    value1 <= 32'sh0fa0;
    enable <= 2'h2;
    settle();
    check(32'(annunciator[0]), 32'h0);
    enable <= 2'h3;
    settle();
    check(32'(annunciator[0]), 32'h1);
    value1 <= 32'sh0;
    view_sel <= alarm_pkg::VIEW_A;
    settle();
    $display("test_rate_high done");
  endtask

  // Low total alarm on a normally closed output
  task automatic test_total_low();
    value2 <= 32'sh32;
    settle();
    check(32'(annunciator[1]), 32'h1);
    check(32'(alarm_switch[1]), 32'h0);
    value2 <= 32'sh3c;
    settle();
    check(32'(alarm_switch), 32'h2);
    $display("test_total_low done");
  endtask

  // Five-second delay: flashing with idle output, then steady and closed
  task automatic test_delay();
    logic s0;
    delay1 <= 12'h005;
    value1 <= 32'sh0fa0;
    repeat (3 * TICK) @(posedge clk_in);
    check(32'(alarm_switch[0]), 32'h0);
    s0 = annunciator[0];
    repeat (TICK) @(posedge clk_in);
    check(32'(annunciator[0] ^ s0), 32'h1);
    repeat (4 * TICK) @(posedge clk_in);
    check(32'(alarm_switch[0]), 32'h1);
    check(32'(annunciator[0]), 32'h1);
    value1 <= 32'sh0;
    delay1 <= 12'h000;
    settle();
    $display("test_delay done");
  endtask

  // P accepts only when a silence time is set
  task automatic test_accept();
    logic s0;
    silence1 <= 12'h003;
    value1 <= 32'sh0fa0;
    settle();
    check(32'(accept_mode), 32'h1);
    panel_u.press(BP);
    check(32'(alarm_switch[0]), 32'h0);
    // Three silenced ticks of flashing, then the output returns
    s0 = annunciator[0];
    repeat (TICK) @(posedge clk_in);
    check(32'(annunciator[0] ^ s0), 32'h1);
    repeat (3 * TICK) @(posedge clk_in);
    check(32'(alarm_switch[0]), 32'h1);
    value1 <= 32'sh0;
    silence1 <= 12'h000;
    settle();
    value1 <= 32'sh0fa0;
    settle();
    check(32'(accept_mode), 32'h0);
    panel_u.press(BP);
    check(32'(alarm_switch[0]), 32'h1);
    value1 <= 32'sh0;
    settle();
    $display("test_accept done");
  endtask

  // Chord ignored, then an unprotected walk through the menu
  task automatic test_menu();
    logic s0;
    panel_u.chord();
    check(32'(flags), 32'h0);
    menu_en <= 1'b1;
    panel_u.chord();
    check(32'(flags), 32'h4);
    panel_u.press(BU);
    check(32'(flags), 32'h2);
    check(32'(sel_alarm), 32'h1);
    panel_u.press(BD);
    check(32'(flags), 32'h4);
    panel_u.press(BP);
    check(32'(flags), 32'h1);
    s0 = digit_flash;
    repeat (TICK) @(posedge clk_in);
    check(32'(digit_flash ^ s0), 32'h1);
    panel_u.press(BE);
    check(32'(flags), 32'h4);
    panel_u.press(BE);
    check(32'(flags), 32'h0);
    $display("test_menu done");
  endtask

  // Protected entry: match, code change, stale code, idle fall-back
  task automatic test_code();
    code_cfg <= 16'h1234;
    code_digits <= 16'h1234;
    settle();
    panel_u.chord();
    check(32'(flags), 32'h10);
    panel_u.press(BP);
    check(32'(flags), 32'h08);
    panel_u.press(BE);
    check(32'(flags), 32'h04);
    // New code counts only from the return to totalising mode
    code_cfg <= 16'h4321;
    panel_u.press(BE);
    panel_u.chord();
    panel_u.press(BP);
    panel_u.press(BE);
    check(32'(flags), 32'h0);
    panel_u.chord();
    check(32'(flags), 32'h10);
    repeat (12 * TICK) @(posedge clk_in);
    check(32'(flags), 32'h0);
    $display("test_code done");
  endtask

  // Cut a hang short
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    {err_total, samples_checked, cycles} = '0;
    {resetn_in, ce_in, flash_en, menu_en} = 4'b0110;
    {value1, value2} = {32'sh0, 32'sh3e8};
    {sp1, sp2, hy1, hy2} = {32'sh0fa0, 32'sh32, 32'sh64, 32'sh0};
    {view_sel, in1_sel, in2_sel} = {alarm_pkg::VIEW_A, 2'h0, 2'h1};
    {enable, high_low, is_rate, pol} = {2'h3, 2'h1, 2'h1, 2'h2};
    {delay1, delay2, silence1, silence2} = '0;
    {code_cfg, code_digits} = '0;
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    test_reset();
    test_rate_high();
    test_total_low();
    test_delay();
    test_accept();
    test_menu();
    test_code();
    end_of_test();
  end
endmodule
`default_nettype wire
